//--- hdl/tivm_top.v
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tivm_consts.vh"
module tivm_top (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire reset_fetch,
  input wire [3:0] trap_req,
  input wire [117:0] irq_req,
  input wire ext_irq3_pin,
  input wire i2c2_master_event,
  input wire i2c2_slave_event,
  output reg vec_valid,
  output reg [23:0] vec_addr,
  output reg [7:0] vec_num,
  output reg vec_is_trap,
  output reg irq_out
);
  // ************************************************************
  // Helper functions
  // ************************************************************
  // Table base chosen by the table select bit
  function [23:0] tbl_base;
    input alt;
    begin
      tbl_base = alt ? `TIVM_ALT_OFFSET : 24'h000000;
    end
  endfunction

  // Word-aligned register decode of an AXI byte address
  function [3:0] reg_ofs;
    input [31:0] a;
    begin
      reg_ofs = {a[3:2], 2'b00};
    end
  endfunction

  // ************************************************************
  // Registers and state
  // ************************************************************
  reg [15:0] flag3_reg; // Third flag status register
  reg [15:0] ctrl_reg; // Table select control
  reg [15:0] irq_en_reg; // Interrupt enable of flag bits
  reg [2:0] ext3_sync_reg; // Synchroniser plus edge history
  reg [1:0] mst_sync_reg; // Master event synchroniser
  reg [1:0] slv_sync_reg; // Slave event synchroniser
  reg [1:0] rst_sync_reg; // Reset fetch request synchroniser
  reg [3:0] trap_s1_reg; // Trap request first stage
  reg [3:0] trap_s2_reg; // Trap request second stage
  reg [117:0] irq_s1_reg; // Interrupt request first stage
  reg [117:0] irq_s2_reg; // Interrupt request second stage
  reg rst_phase_reg; // Second word of reset jump pending
  reg rst_seen_reg; // Reset fetch request history
  reg aw_hold_reg; // Write address captured
  reg w_hold_reg; // Write data captured
  reg [3:0] aw_ofs_reg; // Captured write offset
  reg [31:0] w_data_reg; // Captured write data
  reg [3:0] w_strb_reg; // Captured write strobes
  wire alt_sel; // Alternate table in use
  wire ext3_rise; // External interrupt 3 edge
  wire [15:0] set_vec; // Hardware set pulses per flag bit
  wire wr_go; // Write completes this cycle
  wire wr_ok; // Mapped write completes this cycle
  wire [15:0] wmask; // Byte enable mask of low half
  reg [15:0] clr_vec; // Software clear per flag bit
  reg [15:0] flag3_next; // Next flag value
  reg [23:0] pick_addr; // Winning vector address
  reg [7:0] pick_num; // Winning vector number
  reg pick_trap; // Winner is a trap
  reg pick_valid; // Any request present
  integer i;

  assign alt_sel = ctrl_reg[`TIVM_BIT_ALT];
  assign ext3_rise = ext3_sync_reg[1] & ~ext3_sync_reg[2];
  assign wmask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign wr_go = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  // Unmapped writes alias onto low offsets, so they must not touch any register
  assign wr_ok = wr_go & (s_axi_bresp == 2'b00);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Every outside request passes two flops before use
  always @(posedge aclk) begin
    if (!aresetn) begin
      ext3_sync_reg <= 3'h0;
      mst_sync_reg <= 2'h0;
      slv_sync_reg <= 2'h0;
      rst_sync_reg <= 2'h0;
      trap_s1_reg <= 4'h0;
      trap_s2_reg <= 4'h0;
      irq_s1_reg <= {118{1'b0}};
      irq_s2_reg <= {118{1'b0}};
    end else begin
      ext3_sync_reg <= {ext3_sync_reg[1:0], ext_irq3_pin};
      mst_sync_reg <= {mst_sync_reg[0], i2c2_master_event};
      slv_sync_reg <= {slv_sync_reg[0], i2c2_slave_event};
      rst_sync_reg <= {rst_sync_reg[0], reset_fetch};
      trap_s1_reg <= trap_req;
      trap_s2_reg <= trap_s1_reg;
      irq_s1_reg <= irq_req;
      irq_s2_reg <= irq_s1_reg;
    end
  end

  // ************************************************************
  // Third flag status register
  // ************************************************************
  // Hardware set pulses into their bit positions
  assign set_vec = {10'h000, ext3_rise, 2'b00, mst_sync_reg[1], slv_sync_reg[1], 1'b0};

  // Software clears by writing zero to the flag or one to the clear register
  always @* begin
    clr_vec = 16'h0000;
    if (wr_ok && aw_ofs_reg == `TIVM_OFS_FLAG3) begin
      clr_vec = wmask & ~w_data_reg[15:0];
    end else if (wr_ok && aw_ofs_reg == `TIVM_OFS_IRQ_CLR) begin
      clr_vec = wmask & w_data_reg[15:0];
    end
    // Set wins over clear; unimplemented bits stay zero
    flag3_next = ((flag3_reg & ~clr_vec) | set_vec) & `TIVM_FLAG3_MASK;
  end

  // Flag, control and enable registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag3_reg <= 16'h0000;
      ctrl_reg <= `TIVM_CTRL_RST;
      irq_en_reg <= 16'h0000;
    end else begin
      flag3_reg <= flag3_next;
      if (wr_ok && aw_ofs_reg == `TIVM_OFS_CTRL) begin
        ctrl_reg <= (ctrl_reg & ~wmask) | (w_data_reg[15:0] & wmask & 16'h0001);
      end
      if (wr_ok && aw_ofs_reg == `TIVM_OFS_IRQ_EN) begin
        irq_en_reg <= (irq_en_reg & ~wmask) | (w_data_reg[15:0] & wmask & `TIVM_FLAG3_MASK);
      end
    end
  end

  // Level interrupt, high while an enabled flag is set
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(flag3_next & irq_en_reg);
    end
  end

  // ************************************************************
  // Vector selection
  // ************************************************************
  // Scan from highest number down so the lowest address wins
  always @* begin
    pick_valid = 1'b0;
    pick_trap = 1'b0;
    pick_num = 8'h00;
    pick_addr = 24'h000000;
    for (i = `TIVM_NUM_IRQ - 1; i >= 0; i = i - 1) begin
      if (irq_s2_reg[i]) begin
        pick_valid = 1'b1;
        pick_trap = 1'b0;
        pick_num = i[7:0];
        pick_addr = tbl_base(alt_sel) + `TIVM_IRQ_BASE + {15'h0000, i[7:0], 1'b0};
      end
    end
    // Only sources 1..4 exist; reserved slots 0,5,6,7 never selected
    for (i = 3; i >= 0; i = i - 1) begin
      if (trap_s2_reg[i]) begin
        pick_valid = 1'b1;
        pick_trap = 1'b1;
        pick_num = i[7:0] + 8'h01;
        pick_addr = tbl_base(alt_sel) + `TIVM_TRAP_BASE + {20'h00000, i[2:0] + 3'h1, 1'b0};
      end
    end
  end

  // Vector output; reset fetch outranks everything
  always @(posedge aclk) begin
    if (!aresetn) begin
      vec_valid <= 1'b0;
      vec_addr <= 24'h000000;
      vec_num <= 8'h00;
      vec_is_trap <= 1'b0;
      rst_phase_reg <= 1'b0;
      rst_seen_reg <= 1'b0;
    end else begin
      rst_seen_reg <= rst_sync_reg[1];
      rst_phase_reg <= 1'b0;
      if (rst_sync_reg[1] && !rst_seen_reg) begin
        // Jump instruction word first
        vec_valid <= 1'b1;
        vec_addr <= `TIVM_RESET_INSTR_ADDR;
        vec_num <= 8'h00;
        vec_is_trap <= 1'b0;
        rst_phase_reg <= 1'b1;
      end else if (rst_phase_reg) begin
        // Jump target operand word next
        vec_valid <= 1'b1;
        vec_addr <= `TIVM_RESET_TARGET_ADDR;
        vec_num <= 8'h00;
        vec_is_trap <= 1'b0;
      end else begin
        vec_valid <= pick_valid;
        vec_addr <= pick_addr;
        vec_num <= pick_num;
        vec_is_trap <= pick_trap;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  // Address and data taken in any order, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_ofs_reg <= 4'h0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_hold_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_hold_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_ofs_reg <= reg_ofs(s_axi_awaddr);
        s_axi_bresp <= (s_axi_awaddr[31:4] == 28'h0000000) ? 2'b00 : 2'b10;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        if (s_axi_bresp != 2'b00) begin
          // Unmapped: suppress the register effect
          w_strb_reg <= 4'h0;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  // One read at a time; unmapped answers SLVERR with zero data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (reg_ofs(s_axi_araddr))
          `TIVM_OFS_FLAG3: s_axi_rdata <= {16'h0000, flag3_reg};
          `TIVM_OFS_CTRL: s_axi_rdata <= {16'h0000, ctrl_reg};
          `TIVM_OFS_IRQ_EN: s_axi_rdata <= {16'h0000, irq_en_reg};
          default: s_axi_rdata <= 32'h00000000;
        endcase
        if (s_axi_araddr[31:4] != 28'h0000000) begin
          s_axi_rresp <= 2'b10;
          s_axi_rdata <= 32'h00000000;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/tivm_consts.vh
`ifndef TIVM_CONSTS_VH
`define TIVM_CONSTS_VH
// ************************************************************
// Vector map addresses
// ************************************************************
`define TIVM_RESET_INSTR_ADDR 24'h000000
`define TIVM_RESET_TARGET_ADDR 24'h000002
`define TIVM_TRAP_BASE 24'h000004
`define TIVM_IRQ_BASE 24'h000014
`define TIVM_ALT_OFFSET 24'h000100
`define TIVM_NUM_IRQ 118
`define TIVM_NUM_TRAP 8
// ************************************************************
// Trap vector numbers
// ************************************************************
`define TIVM_TRAP_OSC 3'h1
`define TIVM_TRAP_ADDR 3'h2
`define TIVM_TRAP_STACK 3'h3
`define TIVM_TRAP_MATH 3'h4
// ************************************************************
// Register byte offsets
// ************************************************************
`define TIVM_OFS_FLAG3 4'h0
`define TIVM_OFS_CTRL 4'h4
`define TIVM_OFS_IRQ_EN 4'h8
`define TIVM_OFS_IRQ_CLR 4'hc
// ************************************************************
// Field positions and reset values
// ************************************************************
`define TIVM_BIT_SLAVE 1
`define TIVM_BIT_MASTER 2
`define TIVM_BIT_EXT3 5
`define TIVM_FLAG3_MASK 16'h0026
`define TIVM_BIT_ALT 0
`define TIVM_CTRL_RST 16'h0000
`endif

//--- dv/tivm_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Vector map and flag read checks
// ****************************************
module tivm_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic reset_fetch,
  input wire logic [3:0] trap_req,
  input wire logic [117:0] irq_req,
  input wire logic vec_valid,
  input wire logic [23:0] vec_addr,
  input wire logic [7:0] vec_num,
  input wire logic vec_is_trap
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic rd_flag_reg; // Read in flight targets the flag register
  logic [7:0] low_trap; // Lowest pending trap number
  // Remember which register the current read addresses
  always @(posedge aclk) begin
    if (!aresetn) rd_flag_reg <= 1'b0;
    else if (s_axi_arvalid && s_axi_arready) rd_flag_reg <= (s_axi_araddr[31:2] == 30'h0);
  end
  assign low_trap = trap_req[0] ? 8'h01 : trap_req[1] ? 8'h02 : trap_req[2] ? 8'h03 : 8'h04;
  a_reset_pair: assert property (vec_valid && !vec_is_trap && vec_addr == 24'h0 |=> vec_addr == 24'h2)
    else $error("reset target word missing");
  a_trap_slot: assert property (vec_valid && vec_is_trap |-> vec_num inside {[1:4]} && vec_addr[23:9] == 15'h0 &&
    vec_addr[7:0] == 8'h04 + {vec_num[6:0], 1'b0}) else $error("trap slot wrong");
  a_irq_slot: assert property (vec_valid && !vec_is_trap && vec_addr[7:0] > 8'h02 |-> vec_num < 8'd118 &&
    vec_addr[23:9] == 15'h0 && vec_addr[7:0] == 8'h14 + {vec_num[6:0], 1'b0}) else $error("irq slot wrong");
  a_trap_first: assert property ((trap_req != 4'h0 && $stable(trap_req) && !reset_fetch)[*6] |->
    vec_valid && vec_is_trap && vec_num == low_trap) else $error("trap priority wrong");
  a_irq_lowest: assert property ((trap_req == 4'h0 && irq_req != 118'h0 && $stable(irq_req) && !reset_fetch)[*6] |->
    vec_valid && !vec_is_trap && irq_req[vec_num] && (irq_req & ((118'h1 << vec_num) - 118'h1)) == 118'h0)
    else $error("irq priority wrong");
  a_idle_quiet: assert property ((trap_req == 4'h0 && irq_req == 118'h0 && !reset_fetch)[*6] |-> !vec_valid)
    else $error("vector without source");
  a_flag_zeros: assert property (s_axi_rvalid && rd_flag_reg |-> s_axi_rdata[31:6] == 26'h0 &&
    s_axi_rdata[4:3] == 2'h0 && !s_axi_rdata[0]) else $error("unused flag bits set");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read answer");
  c_reset_fetch: cover property (vec_valid && vec_addr == 24'h2);
  c_alt_trap: cover property (vec_valid && vec_is_trap && vec_addr[8]);
  c_last_irq: cover property (vec_valid && vec_num == 8'd117);
endmodule
bind tivm_top tivm_checker u_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .reset_fetch, .trap_req, .irq_req, .vec_valid, .vec_addr, .vec_num, .vec_is_trap);
`default_nettype wire

//--- dv/tivm_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Core fetch start and request sources
// ****************************************
module tivm_src_model (
  input wire logic aclk,
  output logic reset_fetch,
  output logic [3:0] trap_req,
  output logic [117:0] irq_req,
  output logic ext_irq3_pin,
  output logic i2c2_master_event,
  output logic i2c2_slave_event
);
  // Quiet sources at time zero
  initial begin
    {reset_fetch, ext_irq3_pin, i2c2_master_event, i2c2_slave_event} = 4'h0;
    trap_req = 4'h0;
    irq_req = 118'h0;
  end
  // Held request levels, changed just after an edge
  task set_req(input logic [3:0] t, input logic [117:0] i);
    @(posedge aclk);
    trap_req <= t;
    irq_req <= i;
  endtask
  // One-cycle events: reset fetch, ext irq3, master, slave
  task pulse(input logic [3:0] ev);
    @(posedge aclk);
    {reset_fetch, ext_irq3_pin, i2c2_master_event, i2c2_slave_event} <= ev;
    @(posedge aclk);
    {reset_fetch, ext_irq3_pin, i2c2_master_event, i2c2_slave_event} <= 4'h0;
  endtask
endmodule
`default_nettype wire

//--- dv/trap_interrupt_vector_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module trap_interrupt_vector_map_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, reset_fetch, ext_irq3_pin;
  logic i2c2_master_event, i2c2_slave_event, vec_valid, vec_is_trap, irq_out;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb, trap_req;
  logic [117:0] irq_req;
  logic [23:0] vec_addr;
  logic [7:0] vec_num;
  int err_count, check_count, cyc, n;
  wire [31:0] vec_w = {vec_valid, vec_is_trap, vec_num[6:0], vec_addr[22:0]}; // Packed vector view
  tivm_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_fetch, .trap_req, .irq_req,
    .ext_irq3_pin, .i2c2_master_event, .i2c2_slave_event, .vec_valid, .vec_addr, .vec_num, .vec_is_trap, .irq_out);
  tivm_src_model u_src (.aclk, .reset_fetch, .trap_req, .irq_req, .ext_irq3_pin, .i2c2_master_event,
    .i2c2_slave_event);
  initial aclk = 1'b0;
  always #4 aclk = ~aclk;
  // Hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus write, both channels offered together
  task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      ad = ad | s_axi_awready;
      wd = wd | s_axi_wready;
    end while (!(ad && wd));
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  // Bus read with data and response compare
  task rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Vector outputs settle three cycles after a request change
  task vchk(input logic [31:0] e);
    repeat (4) @(posedge aclk);
    chk(vec_w, e);
  endtask
  task close_out();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(32'h0, 32'h0, 2'h0);
    rd(32'h4, 32'h0, 2'h0);
    rd(32'h10, 32'h0, 2'h2);
    wr(32'h14, 32'h1, 2'h2);
    rd(32'h4, 32'h0, 2'h0);
    // Reset fetch: jump word then its target word
    u_src.pulse(4'h8);
    n = 0;
    while (!vec_valid && n < 10) begin
      @(posedge aclk);
      n++;
    end
    chk(vec_w, 32'h80000000);
    @(posedge aclk);
    chk(vec_w, 32'h80000002);
    // Traps outrank pending irqs 0 and 117, both tables
    for (int alt = 0; alt < 2; alt++) begin
      wr(32'h4, alt, 2'h0);
      for (int t = 0; t < 4; t++) begin
        u_src.set_req(4'hf << t, {1'b1, 116'h0, 1'b1});
        vchk({2'b11, 7'(t + 1), 23'(6 + 2 * t + 256 * alt)});
      end
      u_src.set_req(4'h0, {1'b1, 116'h0, 1'b1});
      vchk({2'b10, 7'h0, 23'(20 + 256 * alt)});
      u_src.set_req(4'h0, {1'b1, 117'h0});
      vchk({2'b10, 7'd117, 23'(254 + 256 * alt)});
    end
    u_src.set_req(4'h0, 118'h0);
    vchk(32'h0);
    // Flags, enable mask and clearing
    wr(32'h8, 32'h4, 2'h0);
    u_src.pulse(4'h4);
    u_src.pulse(4'h2);
    u_src.pulse(4'h1);
    repeat (4) @(posedge aclk);
    chk({31'h0, irq_out}, 32'h1);
    rd(32'h0, 32'h26, 2'h0);
    rd(32'h8, 32'h4, 2'h0);
    rd(32'hc, 32'h0, 2'h0);
    wr(32'hc, 32'h4, 2'h0);
    rd(32'h0, 32'h22, 2'h0);
    chk({31'h0, irq_out}, 32'h0);
    wr(32'h0, 32'h0, 2'h0);
    rd(32'h0, 32'h0, 2'h0);
    close_out();
  end
endmodule
`default_nettype wire
